// ---- hdl/dlm_pkg.sv ----
// ****************************************************************
// delay locked clock manager constants
// ****************************************************************
package dlm_pkg;
    // register byte offsets
    localparam logic [7:0] DLM_CTRL_OFS = 8'h00;
    localparam logic [7:0] DLM_DIVSEL_OFS = 8'h04;
    localparam logic [7:0] DLM_STATUS_OFS = 8'h08;
    localparam logic [7:0] DLM_PERIOD_OFS = 8'h0C;

    // control and status field positions
    localparam int DLM_CTRL_RST_BIT = 0;
    localparam int DLM_CTRL_DCC_BIT = 1;
    localparam int DLM_CTRL_HF_BIT = 2;
    localparam int DLM_CTRL_WAIT_BIT = 3;
    localparam int DLM_STAT_LOCK_BIT = 0;
    localparam int DLM_STAT_STOP_BIT = 1;
    localparam int DLM_STAT_TAP_LSB = 8;

    // reset values
    localparam logic DLM_RST_RESET = 1'b0;
    localparam logic DLM_DCC_RESET = 1'b1;
    localparam logic DLM_HF_RESET = 1'b0;
    localparam logic DLM_WAIT_RESET = 1'b0;

    // divide factor codes, factor = half-units / 2
    typedef enum logic [2:0] {
        DLM_DIV_1P5 = 3'h0,
        DLM_DIV_2 = 3'h1,
        DLM_DIV_2P5 = 3'h2,
        DLM_DIV_3 = 3'h3,
        DLM_DIV_4 = 3'h4,
        DLM_DIV_5 = 3'h5,
        DLM_DIV_8 = 3'h6,
        DLM_DIV_16 = 3'h7
    } dlm_div_t;
    localparam logic [2:0] DLM_DIV_RESET = 3'h1;

    // delay line and lock detection
    localparam int DLM_TAPS = 64;
    localparam int DLM_TAP_W = 6;
    localparam int DLM_PER_W = 16;
    localparam logic [3:0] DLM_LOCK_MATCHES = 4'h8;
endpackage

// ---- hdl/dlm_top.sv ----
// Summary of operation
// - loop reset drops lock within four cycles
// - reset returns all delay taps to zero
// - locked doubled output runs 2x, 50/50 duty
// - before lock doubled output is 1x 25/75
// - divided output uses selectable factor, default two
// - divided duty 50/50, except HF non-integer
// - zero-phase output is delay-compensated source copy
// - quarter, half, three-quarter phase 1x outputs
// - high-frequency variant: half phase only, no doubled
// - 1x duty corrected unless correction disabled
// - lock indicated only after alignment reached
// - startup hold pauses startup until lock
// - lock stays high across permitted clock stop
// - outputs flush then refill over delay line
//
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
module dlm_top
    import dlm_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [3:0] WB_SEL_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic WB_ERR_O,
    input wire logic SOURCE_CLOCK_IN,
    input wire logic FEEDBACK_CLOCK_IN,
    output logic ZERO_PHASE_OUT,
    output logic QUARTER_PHASE_OUT,
    output logic HALF_PHASE_OUT,
    output logic THREE_QUARTER_PHASE_OUT,
    output logic DOUBLED_CLOCK_OUT,
    output logic DIVIDED_CLOCK_OUT,
    output logic LOCKED_OUT,
    output logic STARTUP_HOLD_OUT
);
    import dlm_pkg::*;

    // divide factor in half-units
    function automatic logic [5:0] div_half_units(input logic [2:0] code);
        case (code)
            DLM_DIV_1P5: div_half_units = 6'h03;
            DLM_DIV_2: div_half_units = 6'h04;
            DLM_DIV_2P5: div_half_units = 6'h05;
            DLM_DIV_3: div_half_units = 6'h06;
            DLM_DIV_4: div_half_units = 6'h08;
            DLM_DIV_5: div_half_units = 6'h0A;
            DLM_DIV_8: div_half_units = 6'h10;
            default: div_half_units = 6'h20;
        endcase
    endfunction

    logic loop_rst_q;
    logic dcc_q;
    logic hf_q;
    logic wait_q;
    logic [2:0] div_q;
    logic ack_q;
    logic err_q;
    logic [31:0] rdat_q;
    logic src_prev_q;
    logic fb_prev_q;
    logic [DLM_TAPS-1:0] line_q;
    logic [DLM_TAP_W-1:0] tap_q;
    logic [DLM_PER_W-1:0] per_q;
    logic [DLM_PER_W-1:0] since_q;
    logic per_ok_q;
    logic [3:0] match_q;
    logic locked_q;
    logic dly_prev_q;
    logic [DLM_PER_W-1:0] ph_q;
    logic run_q;
    logic [21:0] dv_pos_q;
    logic out0_q;
    logic out90_q;
    logic out180_q;
    logic out270_q;
    logic dbl_q;
    logic dv_q;
    logic hold_q;

    logic req;
    logic hit;
    logic src_rise;
    logic fb_rise;
    logic dly_now;
    logic dly_rise;
    logic [DLM_PER_W-1:0] hp;
    logic [DLM_PER_W-1:0] qp;
    logic [5:0] n2;
    logic [21:0] dv_len;
    logic [21:0] dv_hi;
    logic aligned;
    logic stopped;

    // ****************************************************************
    // wishbone slave
    // ****************************************************************
    assign req = WB_CYC_I && WB_STB_I && !ack_q && !err_q;
    assign hit = (WB_ADR_I == DLM_CTRL_OFS) || (WB_ADR_I == DLM_DIVSEL_OFS) ||
        (WB_ADR_I == DLM_STATUS_OFS) || (WB_ADR_I == DLM_PERIOD_OFS);

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req && hit;
            err_q <= req && !hit;
            rdat_q <= 32'h0000_0000;
            if (req && !WB_WE_I) begin
                case (WB_ADR_I)
                    DLM_CTRL_OFS: rdat_q <= {28'h0000000, wait_q, hf_q, dcc_q, loop_rst_q};
                    DLM_DIVSEL_OFS: rdat_q <= {29'h0000000, div_q};
                    DLM_STATUS_OFS: rdat_q <= {18'h00000, tap_q, 6'h00, stopped, locked_q};
                    DLM_PERIOD_OFS: rdat_q <= {16'h0000, per_q};
                    default: rdat_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign WB_ACK_O = ack_q;
    assign WB_ERR_O = err_q;
    assign WB_DAT_O = rdat_q;

    // writes land at the request edge; only byte lane 0 holds fields
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            loop_rst_q <= DLM_RST_RESET;
            dcc_q <= DLM_DCC_RESET;
            hf_q <= DLM_HF_RESET;
            wait_q <= DLM_WAIT_RESET;
            div_q <= DLM_DIV_RESET;
        end else if (req && hit && WB_WE_I && WB_SEL_I[0]) begin
            if (WB_ADR_I == DLM_CTRL_OFS) begin
                loop_rst_q <= WB_DAT_I[DLM_CTRL_RST_BIT];
                dcc_q <= WB_DAT_I[DLM_CTRL_DCC_BIT];
                hf_q <= WB_DAT_I[DLM_CTRL_HF_BIT];
                wait_q <= WB_DAT_I[DLM_CTRL_WAIT_BIT];
            end
            if (WB_ADR_I == DLM_DIVSEL_OFS) begin
                div_q <= WB_DAT_I[2:0];
            end
        end
    end

    // ****************************************************************
    // source period measurement and delay line
    // ****************************************************************
    assign src_rise = SOURCE_CLOCK_IN && !src_prev_q;
    assign fb_rise = FEEDBACK_CLOCK_IN && !fb_prev_q;
    assign stopped = per_ok_q && (since_q > per_q);

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            src_prev_q <= 1'b0;
            fb_prev_q <= 1'b0;
            line_q <= '0;
        end else begin
            src_prev_q <= SOURCE_CLOCK_IN;
            fb_prev_q <= FEEDBACK_CLOCK_IN;
            // keeps shifting through a stop so in-flight edges flush out
            line_q <= {line_q[DLM_TAPS-2:0], SOURCE_CLOCK_IN};
        end
    end

    // period survives a short stop so the tap setting stays valid
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            since_q <= '1;
            per_q <= '0;
            per_ok_q <= 1'b0;
        end else if (src_rise) begin
            since_q <= '0;
            // saturated count: no earlier edge; loop reset relearns the period
            if (since_q != 16'hFFFF && (!stopped || loop_rst_q)) begin
                per_q <= since_q + 16'h0001;
                per_ok_q <= 1'b1;
            end
        end else if (since_q != 16'hFFFF) begin
            since_q <= since_q + 16'h0001;
        end
    end

    // ****************************************************************
    // phase comparison and lock
    // ****************************************************************
    assign aligned = per_ok_q && ((since_q == '0) || (since_q == 16'h0001) ||
        (since_q == per_q - 16'h0001));

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            tap_q <= '0;
            match_q <= 4'h0;
            locked_q <= 1'b0;
        end else if (loop_rst_q) begin
            tap_q <= '0;
            match_q <= 4'h0;
            locked_q <= 1'b0;
        end else if (fb_rise && !locked_q) begin
            if (aligned) begin
                if (match_q == DLM_LOCK_MATCHES - 4'h1) begin
                    locked_q <= 1'b1;
                end
                match_q <= match_q + 4'h1;
            end else begin
                // one step per comparison; wraps to try the next edge
                match_q <= 4'h0;
                tap_q <= tap_q + 6'h01;
            end
        end
    end
    // once locked, only a loop reset drops the flag, so a clean stop keeps it

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            hold_q <= 1'b0;
        end else begin
            hold_q <= wait_q && !locked_q;
        end
    end

    // ****************************************************************
    // output clock synthesis
    // ****************************************************************
    assign dly_now = line_q[tap_q];
    assign dly_rise = dly_now && !dly_prev_q;
    assign hp = per_q >> 1;
    assign qp = per_q >> 2;
    assign n2 = div_half_units(div_q);
    assign dv_len = 22'(n2) * 22'(hp);
    assign dv_hi = hf_q && n2[0] ? 22'(n2 >> 1) * 22'(hp) : dv_len >> 1;

    // phase counter restarts at every delayed source edge; saturates when it stops
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            dly_prev_q <= 1'b0;
            ph_q <= '0;
            run_q <= 1'b0;
        end else begin
            dly_prev_q <= dly_now;
            if (dly_rise && per_ok_q) begin
                ph_q <= '0;
                run_q <= 1'b1;
            end else if (ph_q >= per_q - 16'h0001) begin
                run_q <= 1'b0;
            end else begin
                ph_q <= ph_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            dv_pos_q <= '0;
        end else if (!run_q || dv_pos_q >= dv_len - 22'h000001) begin
            dv_pos_q <= '0;
        end else begin
            dv_pos_q <= dv_pos_q + 22'h000001;
        end
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            out0_q <= 1'b0;
            out90_q <= 1'b0;
            out180_q <= 1'b0;
            out270_q <= 1'b0;
            dbl_q <= 1'b0;
            dv_q <= 1'b0;
        end else if (!run_q) begin
            out0_q <= 1'b0;
            out90_q <= 1'b0;
            out180_q <= 1'b0;
            out270_q <= 1'b0;
            dbl_q <= 1'b0;
            dv_q <= 1'b0;
        end else begin
            out0_q <= dcc_q ? (ph_q < hp) : dly_now;
            out180_q <= dcc_q ? (ph_q >= hp) : !dly_now;
            out90_q <= !hf_q && (dcc_q ? (ph_q >= qp && ph_q < hp + qp) :
                line_q[(tap_q + 6'(qp)) % DLM_TAPS]);
            out270_q <= !hf_q && (dcc_q ? (ph_q >= hp + qp || ph_q < qp) :
                !line_q[(tap_q + 6'(qp)) % DLM_TAPS]);
            if (hf_q) begin
                dbl_q <= 1'b0;
            end else if (locked_q) begin
                dbl_q <= (ph_q < qp) || (ph_q >= hp && ph_q < hp + qp);
            end else begin
                dbl_q <= ph_q < qp;
            end
            dv_q <= dv_pos_q < dv_hi;
        end
    end

    assign ZERO_PHASE_OUT = out0_q;
    assign QUARTER_PHASE_OUT = out90_q;
    assign HALF_PHASE_OUT = out180_q;
    assign THREE_QUARTER_PHASE_OUT = out270_q;
    assign DOUBLED_CLOCK_OUT = dbl_q;
    assign DIVIDED_CLOCK_OUT = dv_q;
    assign LOCKED_OUT = locked_q;
    assign STARTUP_HOLD_OUT = hold_q;

    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence reset_req_s;
        loop_rst_q;
    endsequence

    sequence lock_lost_s;
        !locked_q && tap_q == '0;
    endsequence

    lock_drop_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        reset_req_s |=> ##[0:3] !LOCKED_OUT)
        else $error("lock not dropped after loop reset");
    tap_clear_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        reset_req_s |=> lock_lost_s)
        else $error("taps not cleared by loop reset");
    lock_cause_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        $rose(locked_q) |-> $past(fb_rise) && $past(match_q) == DLM_LOCK_MATCHES - 4'h1)
        else $error("lock without enough aligned comparisons");
    lock_keep_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        locked_q && !loop_rst_q |=> locked_q)
        else $error("lock dropped without loop reset");
    dbl_locked_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        locked_q && run_q && !hf_q && ph_q == hp && qp != '0 && !loop_rst_q
        |=> DOUBLED_CLOCK_OUT && (HALF_PHASE_OUT || !$past(dcc_q)))
        else $error("doubled clock missing second pulse");
    dbl_prelock_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        !locked_q && ph_q >= qp && ph_q < hp |=> !DOUBLED_CLOCK_OUT)
        else $error("doubled clock not 25/75 before lock");
    hf_quiet_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        hf_q |=> !QUARTER_PHASE_OUT && !THREE_QUARTER_PHASE_OUT && !DOUBLED_CLOCK_OUT)
        else $error("high frequency variant drives absent output");
    half_inv_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        run_q && dcc_q |=> HALF_PHASE_OUT == !ZERO_PHASE_OUT)
        else $error("half phase not inverse of zero phase");
    raw_duty_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        run_q && !dcc_q |=> ZERO_PHASE_OUT == $past(dly_now))
        else $error("uncorrected output does not follow source");
    hold_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        wait_q && !locked_q ##1 wait_q |-> STARTUP_HOLD_OUT)
        else $error("startup not held before lock");
    stop_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        !run_q |=> !ZERO_PHASE_OUT && !DIVIDED_CLOCK_OUT)
        else $error("outputs running after delay line flushed");
endmodule

// ---- sim/dlm_src_model.sv ----
// ****************************************************************
// source oscillator and clock distribution feedback
// ****************************************************************
module dlm_src_model (
    input wire logic clk,
    input wire logic [7:0] per,
    input wire logic [7:0] hi,
    input wire logic stop,
    input wire logic fb_in,
    output logic src,
    output logic fb
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_q = 8'h00;
    logic [2:0] dly_q = 3'h0;
    // freeze only at the end of a low phase, so a restart opens with a full high
    always_ff @(posedge clk) begin
        if (!(stop && cnt_q == per - 8'h01)) begin
            cnt_q <= (cnt_q == per - 8'h01) ? 8'h00 : cnt_q + 8'h01;
        end
    end
    assign src = (cnt_q < hi);
    // distribution network: three cycles of routing delay
    always_ff @(posedge clk) begin
        dly_q <= {dly_q[1:0], fb_in};
    end
    assign fb = dly_q[2];
endmodule

// ---- sim/dlm_top_tb.sv ----
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, g, e); end end
module dlm_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dlm_pkg::*;
    logic clk, nrst, cyc, stb, we, ack, err, src, fb, stop;
    logic z, q, h, t, dbl, div, lck, hold;
    logic [7:0] adr, hi, per;
    logic [31:0] dat_i, dat_o, r;
    logic [3:0] sel;
    logic [5:0] o;
    logic e;
    int n_fail = 0;
    int check_count = 0;
    int hu[8] = '{3, 4, 5, 6, 8, 10, 16, 32};
    assign o = {div, dbl, t, h, q, z};
    dlm_top u_dut (.CLK_SYS(clk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_DAT_I(dat_i), .WB_SEL_I(sel), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .WB_ERR_O(err), .SOURCE_CLOCK_IN(src), .FEEDBACK_CLOCK_IN(fb), .ZERO_PHASE_OUT(z),
        .QUARTER_PHASE_OUT(q), .HALF_PHASE_OUT(h), .THREE_QUARTER_PHASE_OUT(t),
        .DOUBLED_CLOCK_OUT(dbl), .DIVIDED_CLOCK_OUT(div), .LOCKED_OUT(lck),
        .STARTUP_HOLD_OUT(hold));
    dlm_src_model u_src (.clk(clk), .per(per), .hi(hi), .stop(stop), .fb_in(z), .src(src),
        .fb(fb));
    // ****************************************************************
    // bus and measurement helpers
    // ****************************************************************
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_i <= d;
        sel <= 4'hF;
        @(posedge clk);
        while (ack !== 1'b1 && err !== 1'b1) begin
            @(posedge clk);
            n++;
        end
        `CHK(n, 1)
        r = dat_o;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rise(input int i, output int c);
        for (c = 0; c < 800 && o[i] !== 1'b0; c++) @(negedge clk);
        for (; c < 800 && o[i] !== 1'b1; c++) @(negedge clk);
    endtask
    // skips one whole cycle so a settings change has settled first
    task automatic meas(input int i, output int hc, output int pc);
        rise(i, hc);
        rise(i, hc);
        for (hc = 0; hc < 800 && o[i] === 1'b1; hc++) @(negedge clk);
        for (pc = hc; pc < 800 && o[i] !== 1'b1; pc++) @(negedge clk);
    endtask
    task automatic lock_wait();
        int n;
        for (n = 0; n < 5000 && lck !== 1'b1; n++) @(negedge clk);
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_regs();
        wb(1'b0, DLM_CTRL_OFS, 32'h0);
        `CHK(r, 32'h00000002)
        wb(1'b0, DLM_DIVSEL_OFS, 32'h0);
        `CHK(r, 32'h00000001)
        wb(1'b0, 8'h10, 32'h0);
        `CHK({e, r}, 33'h100000000)
    endtask
    task automatic t_lock();
        lock_wait();
        `CHK(lck, 1'b1)
        wb(1'b0, DLM_STATUS_OFS, 32'h0);
        `CHK(r[DLM_STAT_LOCK_BIT], 1'b1)
        wb(1'b0, DLM_PERIOD_OFS, 32'h0);
        `CHK(r[15:0], 16'h0010)
        `CHK(hold, 1'b0)
    endtask
    task automatic t_phase();
        int hc, pc;
        meas(0, hc, pc);
        `CHK({hc, pc}, {32'd8, 32'd16})
        for (int i = 1; i < 4; i++) begin
            rise(0, hc);
            rise(i, pc);
            `CHK(pc, 4 * i)
        end
        meas(4, hc, pc);
        `CHK({hc, pc}, {32'd4, 32'd8})
    endtask
    task automatic t_div();
        int hc, pc;
        logic acc;
        for (int k = 0; k < 8; k++) begin
            wb(1'b1, DLM_DIVSEL_OFS, k);
            meas(5, hc, pc);
            `CHK({hc, pc}, {hu[k] * 4, hu[k] * 8})
        end
        wb(1'b1, DLM_CTRL_OFS, 32'h6);
        for (int k = 0; k < 3; k += 2) begin
            wb(1'b1, DLM_DIVSEL_OFS, k);
            meas(5, hc, pc);
            `CHK({hc, pc}, {hu[k] * 8 * (k == 0 ? 1 : 2) / (k == 0 ? 3 : 5), hu[k] * 8})
        end
        acc = 1'b0;
        repeat (40) begin
            @(negedge clk);
            acc = acc | dbl | q | t;
        end
        `CHK(acc, 1'b0)
        wb(1'b1, DLM_CTRL_OFS, 32'h2);
        wb(1'b1, DLM_DIVSEL_OFS, 32'h1);
    endtask
    task automatic t_dcc();
        int hc, pc;
        @(posedge clk);
        hi <= 8'h04;
        meas(0, hc, pc);
        `CHK(hc, 8)
        wb(1'b1, DLM_CTRL_OFS, 32'h0);
        meas(0, hc, pc);
        `CHK(hc, 4)
        meas(2, hc, pc);
        `CHK(hc, 12)
        wb(1'b1, DLM_CTRL_OFS, 32'h2);
        @(posedge clk);
        hi <= 8'h08;
    endtask
    task automatic t_stop();
        int c;
        @(posedge clk);
        stop <= 1'b1;
        repeat (300) @(negedge clk);
        `CHK({lck, z}, 2'b10)
        @(posedge clk);
        stop <= 1'b0;
        rise(0, c);
        `CHK(c <= 64, 1'b1)
        repeat (200) @(negedge clk);
        `CHK(lck, 1'b1)
    endtask
    task automatic t_rst();
        int c, pc;
        wb(1'b1, DLM_CTRL_OFS, 32'hB);
        for (c = 0; c < 64 && lck !== 1'b0; c++) @(negedge clk);
        `CHK(lck, 1'b0)
        wb(1'b0, DLM_STATUS_OFS, 32'h0);
        `CHK(r[13:8], 6'h00)
        `CHK(hold, 1'b1)
        meas(4, c, pc);
        `CHK({c, pc}, {32'd4, 32'd16})
        wb(1'b1, DLM_CTRL_OFS, 32'hA);
        lock_wait();
        // hold output is registered one cycle behind the lock flag
        @(negedge clk);
        `CHK({lck, hold}, 2'b10)
        wb(1'b1, DLM_CTRL_OFS, 32'h2);
    endtask
    // stop the source and restart it at a new period, then reset and relock
    task automatic t_freq();
        int hc, pc;
        @(posedge clk);
        stop <= 1'b1;
        repeat (100) @(negedge clk);
        @(posedge clk);
        stop <= 1'b0;
        per <= 8'h14;
        hi <= 8'h0A;
        repeat (100) @(negedge clk);
        `CHK(lck, 1'b1)
        wb(1'b1, DLM_CTRL_OFS, 32'h3);
        repeat (50) @(negedge clk);
        wb(1'b1, DLM_CTRL_OFS, 32'h2);
        lock_wait();
        `CHK(lck, 1'b1)
        wb(1'b0, DLM_PERIOD_OFS, 32'h0);
        `CHK(r[15:0], 16'h0014)
        meas(0, hc, pc);
        `CHK({hc, pc}, {32'd10, 32'd20})
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (80000) @(posedge clk);
        n_fail++;
        test_done();
    end
    initial begin
        {nrst, cyc, stb, we, stop, adr, dat_i, sel} = '0;
        hi = 8'h08;
        per = 8'h10;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_lock();
        t_phase();
        t_div();
        t_dcc();
        t_stop();
        t_rst();
        t_freq();
        test_done();
    end
endmodule
